// >>> rtl/mrhm_monitor.sv
// rtp media header monitor with ahb-lite register slave
// What this block does
// - payload header parsed only for media type
// - source role 0 primary, 1 protect, else reserved
// - frame counter must step by one per frame
// - timestamp reference: 1 flagged illegal, others valid
// - nonzero scrambling code reported reserved
// - fec code above two reported reserved
// - word clock codes above five reported reserved
// - mapping code above two reported reserved
// - unknown raster codes reported reserved
// - frame rate codes decoded, gaps reserved
// - sampling codes four and above eight reserved
// - skip header extension words of four octets
// - version must be two; shown and flagged
// - padding octets excluded from media count
// - marker period checked against expected rate
// - sequence must advance by exactly one
// - video and data mode timestamp step checked per frame
// - audio timestamp step checked per packet
// - payload types 98, 99, 33 classified
`timescale 1ns/100ps
module mrhm_monitor #(
   parameter int CLK_HZ = 50000000
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic pkt_valid,
   input wire logic [7:0] pkt_data,
   input wire logic pkt_sop,
   input wire logic pkt_eop,
   output logic [mrhm_pkg::ERR_W-1:0] err_flags
);
   mrhm_pkg::mrhm_state_t s;
   mrhm_pkg::mrhm_state_t n;
   logic take;
   logic pkt_done;
   logic jump;
   logic [17:0] jump_len;
   mrhm_pkg::mrhm_pstate_t jump_st;
   logic [15:0] seq;
   logic [31:0] ts;
   logic mark;
   logic frm_start;
   logic [7:0] fc;
   logic [23:0] exp_per;
   logic [23:0] per_diff;
   logic [15:0] media_calc;
   localparam int ERR_W_L = mrhm_pkg::ERR_W;
   logic [ERR_W_L-1:0] new_err;

   function automatic mrhm_pkg::mrhm_pstate_t after_x(input logic [6:0] pt);
      after_x = (pt == mrhm_pkg::PT_HBR) ? mrhm_pkg::ST_HBR : mrhm_pkg::ST_PAY;
   endfunction

   function automatic logic [23:0] frate_period(input logic [7:0] code);
      unique case (code)
         8'h10: frate_period = 24'(CLK_HZ / 60);
         8'h11: frate_period = 24'(CLK_HZ / 1000 * 1001 / 60);
         8'h12: frate_period = 24'(CLK_HZ / 50);
         8'h14: frate_period = 24'(CLK_HZ / 48);
         8'h15: frate_period = 24'(CLK_HZ / 1000 * 1001 / 48);
         8'h16: frate_period = 24'(CLK_HZ / 30);
         8'h17: frate_period = 24'(CLK_HZ / 1000 * 1001 / 30);
         8'h18: frate_period = 24'(CLK_HZ / 25);
         8'h1A: frate_period = 24'(CLK_HZ / 24);
         8'h1B: frate_period = 24'(CLK_HZ / 1000 * 1001 / 24);
         default: frate_period = 24'h00_0000;
      endcase
   endfunction

   function automatic logic [10:0] decode(input logic [63:0] h, input logic [6:0] pt);
      logic [7:0] fr;
      logic [7:0] rt;
      logic [3:0] sm;
      logic [1:0] cls;
      fr = h[mrhm_pkg::H_FRAME +: 8];
      rt = h[mrhm_pkg::H_FRATE +: 8];
      sm = h[mrhm_pkg::H_SAMPLE +: 4];
      cls = (pt == mrhm_pkg::PT_HBR) ? 2'h1 : (pt == mrhm_pkg::PT_FEC) ? 2'h2 :
         (pt == mrhm_pkg::PT_TSE) ? 2'h3 : 2'h0;
      decode[0] = h[mrhm_pkg::H_VSID +: 3] > 3'h1;
      decode[1] = h[mrhm_pkg::H_REF +: 2] == 2'h1;
      decode[2] = h[mrhm_pkg::H_SCR +: 2] != 2'h0;
      decode[3] = h[mrhm_pkg::H_FEC +: 3] > 3'h2;
      decode[4] = h[mrhm_pkg::H_CF +: 4] > 4'h5;
      decode[5] = h[mrhm_pkg::H_MAP +: 4] > 4'h2;
      decode[6] = !(fr == 8'h00 || fr == 8'h10 || fr == 8'h11 || fr == 8'h30 ||
         (fr >= 8'h20 && fr <= 8'h24));
      decode[7] = (rt >= 8'h05 && rt <= 8'h0F) || rt == 8'h13 || rt == 8'h19 ||
         rt >= 8'h1C;
      decode[8] = sm == 4'h4 || sm > 4'h8;
      decode[10:9] = cls;
   endfunction

   function automatic logic [31:0] rd(input mrhm_pkg::mrhm_state_t q, input logic [7:0] a);
      unique case (a)
         mrhm_pkg::A_CTRL: rd = {28'h000_0000, q.mode, 2'h0} | 32'(q.en);
         mrhm_pkg::A_TS_STEP: rd = q.ts_step;
         mrhm_pkg::A_MARK_PER: rd = {8'h00, q.mark_per};
         mrhm_pkg::A_ERR: rd = {27'h000_0000, q.err};
         mrhm_pkg::A_RTP0: rd = q.lrtp[95:64];
         mrhm_pkg::A_RTP_TS: rd = q.lrtp[63:32];
         mrhm_pkg::A_SSRC: rd = q.lrtp[31:0];
         mrhm_pkg::A_HBR0: rd = q.lhbr[63:32];
         mrhm_pkg::A_HBR1: rd = q.lhbr[31:0];
         mrhm_pkg::A_VTS: rd = q.lvts;
         mrhm_pkg::A_DECODE: rd = {21'h00_0000, decode(q.lhbr, q.lrtp[mrhm_pkg::R_PT +: 7])};
         mrhm_pkg::A_MEDIA: rd = {16'h0000, q.media};
         default: rd = 32'h0000_0000;
      endcase
   endfunction

   assign take = pkt_valid && s.en;

   always_comb
   begin
      n = s;
      n.clr = 1'b0;
      jump = 1'b0;
      jump_len = 18'h0_0000;
      jump_st = mrhm_pkg::ST_PAY;
      n.mcnt = s.mcnt + 24'(~&s.mcnt);
      // register slave: address phase, then write data phase
      if (hsel && htrans[1] && hready)
      begin
         n.aw = hwrite;
         n.aidx = haddr[7:0];
         n.rdata = hwrite ? 32'h0000_0000 : rd(s, haddr[7:0]);
      end
      else
      begin
         n.aw = 1'b0;
      end
      if (s.aw)
      begin
         unique case (s.aidx)
            mrhm_pkg::A_CTRL:
            begin
               n.en = hwdata[mrhm_pkg::C_EN];
               n.clr = hwdata[mrhm_pkg::C_CLR];
               n.mode = hwdata[mrhm_pkg::C_MODE +: 2];
            end
            mrhm_pkg::A_TS_STEP: n.ts_step = hwdata;
            mrhm_pkg::A_MARK_PER: n.mark_per = hwdata[23:0];
            default: n.mark_per = s.mark_per;
         endcase
      end
      // header walk, one octet per accepted beat
      if (take)
      begin
         if (pkt_sop)
         begin
            n.rtp = {s.rtp[87:0], pkt_data};
            n.cnt = 4'h1;
            n.st = mrhm_pkg::ST_RTP;
            n.hdr_ok = 1'b0;
            n.hbr_ok = 1'b0;
            n.vts_ok = 1'b0;
            n.paycnt = 16'h0000;
            n.lastb = 8'h00;
         end
         else
         begin
            unique case (s.st)
               mrhm_pkg::ST_IDLE: n.st = mrhm_pkg::ST_IDLE;
               mrhm_pkg::ST_RTP:
               begin
                  n.rtp = {s.rtp[87:0], pkt_data};
                  n.cnt = s.cnt + 4'h1;
                  if (s.cnt == mrhm_pkg::RTP_LAST)
                  begin
                     n.hdr_ok = 1'b1;
                     jump = 1'b1;
                     jump_len = 18'(n.rtp[mrhm_pkg::R_CC +: 4]) << mrhm_pkg::WORD_SH;
                     jump_st = n.rtp[mrhm_pkg::R_EXT] ? mrhm_pkg::ST_XHDR :
                        after_x(n.rtp[mrhm_pkg::R_PT +: 7]);
                  end
               end
               mrhm_pkg::ST_SKIP:
               begin
                  n.skip = s.skip - 18'h0_0001;
                  if (s.skip == 18'h0_0001)
                  begin
                     n.st = s.ret;
                     n.cnt = 4'h0;
                  end
               end
               mrhm_pkg::ST_XHDR:
               begin
                  n.xlen = {s.xlen[7:0], pkt_data};
                  n.cnt = s.cnt + 4'h1;
                  if (s.cnt == mrhm_pkg::XH_LAST)
                  begin
                     jump = 1'b1;
                     jump_len = 18'(n.xlen) << mrhm_pkg::WORD_SH;
                     jump_st = after_x(s.rtp[mrhm_pkg::R_PT +: 7]);
                  end
               end
               mrhm_pkg::ST_HBR:
               begin
                  n.hbr = {s.hbr[55:0], pkt_data};
                  n.cnt = s.cnt + 4'h1;
                  if (s.cnt == mrhm_pkg::HBR_LAST)
                  begin
                     n.hbr_ok = 1'b1;
                     jump = 1'b1;
                     if (n.hbr[mrhm_pkg::H_CF +: 4] != 4'h0)
                     begin
                        jump_st = mrhm_pkg::ST_VTS;
                     end
                     else
                     begin
                        jump_len = 18'(n.hbr[mrhm_pkg::H_EXT +: 4]) << mrhm_pkg::WORD_SH;
                     end
                  end
               end
               mrhm_pkg::ST_VTS:
               begin
                  n.vts = {s.vts[23:0], pkt_data};
                  n.cnt = s.cnt + 4'h1;
                  if (s.cnt == mrhm_pkg::VTS_LAST)
                  begin
                     n.vts_ok = 1'b1;
                     jump = 1'b1;
                     jump_len = 18'(s.hbr[mrhm_pkg::H_EXT +: 4]) << mrhm_pkg::WORD_SH;
                  end
               end
               mrhm_pkg::ST_PAY:
               begin
                  n.paycnt = s.paycnt + 16'h0001;
                  n.lastb = pkt_data;
               end
               default: n.st = mrhm_pkg::ST_IDLE;
            endcase
         end
      end
      if (jump)
      begin
         n.cnt = 4'h0;
         n.skip = jump_len;
         n.ret = jump_st;
         n.st = (jump_len == 18'h0_0000) ? jump_st : mrhm_pkg::ST_SKIP;
      end
      // packet end: continuity and rate checks
      pkt_done = take && pkt_eop && n.hdr_ok;
      seq = n.rtp[mrhm_pkg::R_SEQ +: 16];
      ts = n.rtp[mrhm_pkg::R_TS +: 32];
      mark = n.rtp[mrhm_pkg::R_MARK];
      fc = n.hbr[mrhm_pkg::H_FC +: 8];
      frm_start = s.have_prev && s.prev_mark;
      media_calc = (n.rtp[mrhm_pkg::R_PAD] && n.paycnt >= 16'(n.lastb)) ?
         n.paycnt - 16'(n.lastb) : (n.rtp[mrhm_pkg::R_PAD] ? 16'h0000 : n.paycnt);
      exp_per = (s.mode == mrhm_pkg::MODE_HBR) ?
         frate_period(n.hbr[mrhm_pkg::H_FRATE +: 8]) : s.mark_per;
      per_diff = (s.mcnt > exp_per) ? s.mcnt - exp_per : exp_per - s.mcnt;
      new_err = '0;
      if (pkt_done)
      begin
         new_err[mrhm_pkg::E_SEQ] = s.have_prev && seq != s.prev_seq + 16'h0001;
         if (s.mode == mrhm_pkg::MODE_HBR || s.mode == mrhm_pkg::MODE_AUD)
         begin
            new_err[mrhm_pkg::E_TS] = s.have_prev && ts - s.prev_ts != s.ts_step;
         end
         else
         begin
            new_err[mrhm_pkg::E_TS] = frm_start && s.have_frm && ts - s.frm_ts != s.ts_step;
         end
         new_err[mrhm_pkg::E_FC] = n.hbr_ok && frm_start && s.have_fc &&
            fc != s.prev_fc + 8'h01;
         new_err[mrhm_pkg::E_MARK] = mark && s.have_mark && s.mode != mrhm_pkg::MODE_AUD &&
            exp_per != 24'h00_0000 && per_diff > (exp_per >> mrhm_pkg::MARK_TOL_SH);
         new_err[mrhm_pkg::E_VER] = n.rtp[mrhm_pkg::R_VER +: 2] != mrhm_pkg::RTP_VERSION;
      end
      // session clear drops baselines; a new event still wins
      if (s.clr)
      begin
         n.have_prev = 1'b0;
         n.have_frm = 1'b0;
         n.have_fc = 1'b0;
         n.have_mark = 1'b0;
      end
      n.err = (s.clr ? '0 : s.err) | new_err;
      if (pkt_done)
      begin
         n.prev_seq = seq;
         n.prev_ts = ts;
         n.prev_mark = mark;
         n.have_prev = 1'b1;
         if (frm_start)
         begin
            n.frm_ts = ts;
            n.have_frm = 1'b1;
         end
         if (n.hbr_ok)
         begin
            n.prev_fc = fc;
            n.have_fc = 1'b1;
            n.lhbr = n.hbr;
         end
         if (mark)
         begin
            n.mcnt = 24'h00_0000;
            n.have_mark = 1'b1;
         end
         n.lrtp = n.rtp;
         n.lvts = n.vts_ok ? n.vts : 32'h0000_0000;
         n.media = media_calc;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
         s.en <= mrhm_pkg::EN_RST;
         s.mode <= mrhm_pkg::MODE_RST;
         s.ts_step <= mrhm_pkg::TS_STEP_RST;
         s.mark_per <= mrhm_pkg::MARK_PER_RST;
      end
      else
      begin
         s <= n;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign err_flags = s.err;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_seq_err_set: assert property (
      pkt_done && s.have_prev && !s.clr && seq != s.prev_seq + 16'h0001
         |=> err_flags[mrhm_pkg::E_SEQ]) else $error("sequence gap not flagged");
   a_seq_ok_quiet: assert property (
      pkt_done && s.have_prev && seq == s.prev_seq + 16'h0001 && !s.err[mrhm_pkg::E_SEQ]
         |=> !err_flags[mrhm_pkg::E_SEQ]) else $error("good sequence flagged");
   a_err_sticky: assert property (
      !s.clr |=> (err_flags & $past(err_flags)) == $past(err_flags))
      else $error("error flag dropped without clear");
   a_clear_empties: assert property (
      s.clr && !pkt_done |=> err_flags == '0) else $error("session clear left flags");
   a_baseline_quiet: assert property (
      pkt_done && !s.have_prev && n.rtp[mrhm_pkg::R_VER +: 2] == mrhm_pkg::RTP_VERSION
         && s.err == '0 |=> err_flags == '0) else $error("first packet raised error");
   a_version_shown: assert property (
      pkt_done |=> s.lrtp[mrhm_pkg::R_VER +: 2] == $past(n.rtp[mrhm_pkg::R_VER +: 2])
         && (s.lrtp[mrhm_pkg::R_VER +: 2] == mrhm_pkg::RTP_VERSION || s.err[mrhm_pkg::E_VER]))
      else $error("version not shown or flagged");
   a_hbr_gated: assert property (
      pkt_done && n.rtp[mrhm_pkg::R_PT +: 7] != mrhm_pkg::PT_HBR |=> s.lhbr == $past(s.lhbr))
      else $error("payload header taken for other type");
   a_pad_excluded: assert property (
      pkt_done && n.rtp[mrhm_pkg::R_PAD] && n.paycnt >= 16'(n.lastb)
         |=> s.media == $past(n.paycnt) - 16'($past(n.lastb)))
      else $error("padding counted as media");
   a_fc_step: assert property (
      pkt_done && n.hbr_ok && frm_start && s.have_fc && fc != s.prev_fc + 8'h01
         |=> err_flags[mrhm_pkg::E_FC]) else $error("frame count jump not flagged");
   a_unmapped_zero: assert property (
      hsel && htrans[1] && hready && !hwrite && haddr[7:0] > mrhm_pkg::A_MEDIA
         |=> hrdata == 32'h0000_0000 && hreadyout && !hresp)
      else $error("unmapped read not zero");
endmodule

// >>> rtl/mrhm_pkg.sv
// constants, states and state record of the rtp header monitor
package mrhm_pkg;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_TS_STEP = 8'h04;
   localparam logic [7:0] A_MARK_PER = 8'h08;
   localparam logic [7:0] A_ERR = 8'h0C;
   localparam logic [7:0] A_RTP0 = 8'h10;
   localparam logic [7:0] A_RTP_TS = 8'h14;
   localparam logic [7:0] A_SSRC = 8'h18;
   localparam logic [7:0] A_HBR0 = 8'h1C;
   localparam logic [7:0] A_HBR1 = 8'h20;
   localparam logic [7:0] A_VTS = 8'h24;
   localparam logic [7:0] A_DECODE = 8'h28;
   localparam logic [7:0] A_MEDIA = 8'h2C;
   localparam int C_EN = 0;
   localparam int C_CLR = 1;
   localparam int C_MODE = 2;
   localparam logic [1:0] MODE_HBR = 2'h0;
   localparam logic [1:0] MODE_VID = 2'h1;
   localparam logic [1:0] MODE_AUD = 2'h2;
   localparam logic [1:0] MODE_DAT = 2'h3;
   localparam logic EN_RST = 1'b1;
   localparam logic [1:0] MODE_RST = MODE_HBR;
   localparam logic [31:0] TS_STEP_RST = 32'h0000_0000;
   localparam logic [23:0] MARK_PER_RST = 24'h00_0000;
   localparam int ERR_W = 5;
   localparam int E_SEQ = 0;
   localparam int E_TS = 1;
   localparam int E_FC = 2;
   localparam int E_MARK = 3;
   localparam int E_VER = 4;
   localparam logic [1:0] RTP_VERSION = 2'h2;
   localparam logic [6:0] PT_HBR = 7'h62;
   localparam logic [6:0] PT_FEC = 7'h63;
   localparam logic [6:0] PT_TSE = 7'h21;
   localparam logic [3:0] RTP_LAST = 4'hB;
   localparam logic [3:0] XH_LAST = 4'h3;
   localparam logic [3:0] HBR_LAST = 4'h7;
   localparam logic [3:0] VTS_LAST = 4'h3;
   localparam int WORD_SH = 2;
   localparam int MARK_TOL_SH = 6;
   // fixed rtp header, first octet at the top
   localparam int R_VER = 94;
   localparam int R_PAD = 93;
   localparam int R_EXT = 92;
   localparam int R_CC = 88;
   localparam int R_MARK = 87;
   localparam int R_PT = 80;
   localparam int R_SEQ = 64;
   localparam int R_TS = 32;
   // media payload header, first octet at the top
   localparam int H_EXT = 60;
   localparam int H_FMT = 59;
   localparam int H_VSID = 56;
   localparam int H_FC = 48;
   localparam int H_REF = 46;
   localparam int H_SCR = 44;
   localparam int H_FEC = 41;
   localparam int H_CF = 37;
   localparam int H_MAP = 28;
   localparam int H_FRAME = 20;
   localparam int H_FRATE = 12;
   localparam int H_SAMPLE = 8;

   typedef enum logic [2:0] {ST_IDLE, ST_RTP, ST_SKIP, ST_XHDR, ST_HBR, ST_VTS, ST_PAY}
      mrhm_pstate_t;

   typedef struct packed {
      logic en;
      logic [1:0] mode;
      logic clr;
      logic [31:0] ts_step;
      logic [23:0] mark_per;
      logic aw;
      logic [7:0] aidx;
      logic [31:0] rdata;
      mrhm_pstate_t st;
      mrhm_pstate_t ret;
      logic [3:0] cnt;
      logic [17:0] skip;
      logic [95:0] rtp;
      logic [15:0] xlen;
      logic [63:0] hbr;
      logic [31:0] vts;
      logic hdr_ok;
      logic hbr_ok;
      logic vts_ok;
      logic [15:0] paycnt;
      logic [7:0] lastb;
      logic [15:0] prev_seq;
      logic [31:0] prev_ts;
      logic prev_mark;
      logic have_prev;
      logic [31:0] frm_ts;
      logic have_frm;
      logic [7:0] prev_fc;
      logic have_fc;
      logic [23:0] mcnt;
      logic have_mark;
      logic [ERR_W-1:0] err;
      logic [95:0] lrtp;
      logic [63:0] lhbr;
      logic [31:0] lvts;
      logic [15:0] media;
   } mrhm_state_t;
endpackage

// >>> verif/mrhm_tx_model.sv
// remote rtp transmitter model driving the packet byte stream
`timescale 1ns/100ps
module mrhm_tx_model (
   input wire logic hclk,
   output logic pkt_valid,
   output logic [7:0] pkt_data,
   output logic pkt_sop,
   output logic pkt_eop
);
   logic [7:0] q[$];
   initial
   begin
      pkt_valid = 1'b0;
      pkt_data = 8'h00;
      pkt_sop = 1'b0;
      pkt_eop = 1'b0;
   end
   task automatic put32(input logic [31:0] w);
      for (int i = 3; i >= 0; i--)
      begin
         q.push_back(w[i*8 +: 8]);
      end
   endtask
   // header, optional payload header, video stamp, extension, payload, padding
   task automatic send(input logic [1:0] ver, input logic pad, input logic mark,
      input logic [6:0] pt, input logic [15:0] seq, input logic [31:0] ts,
      input logic [63:0] hbr, input int npay, input int npad);
      logic [63:0] w;
      q = {};
      w = hbr & 64'hFFFF_FFE0_FFFF_FF00;
      put32({ver, pad, 1'b0, 4'h0, mark, pt, seq});
      put32(ts);
      put32(32'h1234_5678);
      if (pt == mrhm_pkg::PT_HBR)
      begin
         put32(w[63:32]);
         put32(w[31:0]);
         if (w[40:37] != 4'h0)
         begin
            put32(ts);
         end
         for (int i = 0; i < 4 * w[63:60]; i++)
         begin
            q.push_back(8'hEE);
         end
      end
      for (int i = 0; i < npay; i++)
      begin
         q.push_back(8'(i));
      end
      for (int i = 0; i < npad; i++)
      begin
         q.push_back((i == npad - 1) ? 8'(npad) : 8'h00);
      end
      for (int i = 0; i < q.size(); i++)
      begin
         pkt_valid <= 1'b1;
         pkt_data <= q[i];
         pkt_sop <= (i == 0);
         pkt_eop <= (i == q.size() - 1);
         @(posedge hclk);
      end
      pkt_valid <= 1'b0;
      pkt_sop <= 1'b0;
      pkt_eop <= 1'b0;
      pkt_data <= ~q[q.size() - 1];
      @(posedge hclk);
   endtask
   task automatic gap(input int n);
      repeat (n) @(posedge hclk);
   endtask
endmodule

// >>> verif/tb_mrhm_monitor.sv
// self-checking bench of the rtp header monitor
`timescale 1ns/100ps
module tb_mrhm_monitor;
   localparam logic [31:0] STEP = 32'h0000_0100;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic pkt_valid;
   logic [7:0] pkt_data;
   logic pkt_sop;
   logic pkt_eop;
   logic [mrhm_pkg::ERR_W-1:0] err_flags;
   logic [15:0] seq = 16'hFFFD;
   logic [31:0] ts = 32'hFFFF_FE00;
   logic [31:0] rd;
   logic [7:0] fc = 8'hFE;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   mrhm_monitor #(.CLK_HZ(6000)) mrhm_monitor_inst (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_sop(pkt_sop),
      .pkt_eop(pkt_eop), .err_flags(err_flags));
   mrhm_tx_model mrhm_tx_model_inst (.hclk(hclk), .pkt_valid(pkt_valid),
      .pkt_data(pkt_data), .pkt_sop(pkt_sop), .pkt_eop(pkt_eop));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (fails == 0 && samples_checked > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // single ahb-lite transfer; waits on hready in both phases
   task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xf(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask
   task automatic ef(input logic [4:0] exp);
      @(negedge hclk);
      chk({27'h0, err_flags}, {27'h0, exp});
      @(posedge hclk);
   endtask
   task automatic sess(input logic [1:0] m);
      xf(mrhm_pkg::A_CTRL, 1'b1, {28'h0, m, 2'b11});
      repeat (2) @(posedge hclk);
   endtask
   task automatic pkt(input logic [1:0] v, input logic mk, input logic [6:0] pt,
      input logic [63:0] h, input logic [15:0] sd, input logic [31:0] td);
      seq = seq + sd;
      ts = ts + td;
      mrhm_tx_model_inst.send(v, 1'b0, mk, pt, seq, ts, h, 4, 0);
   endtask
   function automatic logic [63:0] hf(input logic [3:0] x, input logic [2:0] v,
      input logic [7:0] f, input logic [10:0] a, input logic [23:0] b);
      return {x, 1'b1, v, f, a, 5'h00, b, 8'h00};
   endfunction
   task automatic s_regs();
      chk({31'h0, hresp}, 32'h0);
      chk({27'h0, err_flags}, 32'h0);
      rdc(mrhm_pkg::A_CTRL, {28'h0, mrhm_pkg::MODE_RST, 1'b0, mrhm_pkg::EN_RST});
      rdc(mrhm_pkg::A_MARK_PER, 32'h0);
      xf(mrhm_pkg::A_ERR, 1'b1, 32'h0000_001F);
      rdc(mrhm_pkg::A_ERR, 32'h0);
      rdc(8'hFC, 32'h0);
      xf(mrhm_pkg::A_TS_STEP, 1'b1, STEP);
      rdc(mrhm_pkg::A_TS_STEP, STEP);
   endtask
   task automatic s_seq();
      sess(mrhm_pkg::MODE_HBR);
      pkt(2'h2, 1'b0, 7'h60, 64'h0, 16'h0, 32'h0000_1234);
      ef(5'h00);
      for (int i = 0; i < 3; i++)
      begin
         pkt(2'h2, 1'b0, 7'h60, 64'h0, 16'h1, STEP);
      end
      ef(5'h00);
      pkt(2'h2, 1'b0, 7'h60, 64'h0, 16'h2, STEP);
      ef(5'h01);
      pkt(2'h2, 1'b0, 7'h60, 64'h0, 16'h1, STEP);
      ef(5'h01);
      pkt(2'h1, 1'b0, 7'h60, 64'h0, 16'h1, STEP);
      ef(5'h11);
      xf(mrhm_pkg::A_RTP0, 1'b0, 32'h0);
      chk({30'h0, rd[31:30]}, 32'h1);
      rdc(mrhm_pkg::A_ERR, 32'h11);
      sess(mrhm_pkg::MODE_HBR);
      ef(5'h00);
   endtask
   task automatic s_ts();
      for (int m = 0; m < 4; m++)
      begin
         sess(2'(m));
         pkt(2'h2, 1'(m), 7'h60, 64'h0, 16'h1, 32'h0000_0777);
         pkt(2'h2, 1'(m), 7'h60, 64'h0, 16'h1, STEP);
         ef(5'h00);
         pkt(2'h2, 1'(m), 7'h60, 64'h0, 16'h1, STEP + 32'h1);
         ef(5'h02);
      end
   endtask
   task automatic s_hbr();
      sess(mrhm_pkg::MODE_HBR);
      for (int i = 0; i < 3; i++)
      begin
         pkt(2'h2, 1'b1, mrhm_pkg::PT_HBR,
            hf(4'h0, 3'h1, fc, {2'h2, 2'h0, 3'h2, 4'h5}, {4'h2, 8'h24, 8'h04, 4'h8}),
            16'h1, STEP);
         fc = fc + 8'h01;
      end
      ef(5'h00);
      rdc(mrhm_pkg::A_DECODE, 32'h0000_0200);
      fc = fc + 8'h01;
      pkt(2'h2, 1'b1, mrhm_pkg::PT_HBR, hf(4'h0, 3'h0, fc, 11'h0, 24'h0), 16'h1, STEP);
      ef(5'h04);
      pkt(2'h2, 1'b0, mrhm_pkg::PT_HBR,
         hf(4'h2, 3'h2, fc, {2'h1, 2'h1, 3'h3, 4'h6}, {4'h3, 8'h12, 8'h13, 4'h4}),
         16'h1, STEP);
      rdc(mrhm_pkg::A_DECODE, 32'h0000_03FF);
      rdc(mrhm_pkg::A_MEDIA, 32'h4);
   endtask
   task automatic s_media();
      logic [6:0] pts[4] = '{7'h62, 7'h63, 7'h21, 7'h60};
      mrhm_tx_model_inst.send(2'h2, 1'b1, 1'b0, 7'h60, seq, ts, 64'h0, 6, 3);
      rdc(mrhm_pkg::A_MEDIA, 32'h6);
      for (int i = 0; i < 4; i++)
      begin
         pkt(2'h2, 1'b0, pts[i], 64'h0, 16'h1, STEP);
         xf(mrhm_pkg::A_DECODE, 1'b0, 32'h0);
         chk({30'h0, rd[10:9]}, 32'((i + 1) % 4));
         rdc(mrhm_pkg::A_MEDIA, 32'h4);
      end
   endtask
   task automatic s_mark();
      sess(mrhm_pkg::MODE_VID);
      xf(mrhm_pkg::A_MARK_PER, 1'b1, 32'h0000_00C8);
      for (int i = 0; i < 4; i++)
      begin
         pkt(2'h2, 1'b1, 7'h60, 64'h0, 16'h1, STEP);
         mrhm_tx_model_inst.gap(184);
      end
      pkt(2'h2, 1'b1, 7'h60, 64'h0, 16'h1, STEP);
      ef(5'h00);
      mrhm_tx_model_inst.gap(283);
      pkt(2'h2, 1'b1, 7'h60, 64'h0, 16'h1, STEP);
      ef(5'h08);
      sess(mrhm_pkg::MODE_HBR);
      for (int i = 0; i < 3; i++)
      begin
         fc = fc + 8'h01;
         pkt(2'h2, 1'b1, mrhm_pkg::PT_HBR,
            hf(4'h0, 3'h0, fc, 11'h0, 24'h00_0100), 16'h1, STEP);
         if (i == 1)
         begin
            ef(5'h00);
         end
         mrhm_tx_model_inst.gap(76 + 20 * i);
      end
      ef(5'h08);
   endtask
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         end_of_test();
      end
   end
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      s_regs();
      s_seq();
      s_ts();
      s_hbr();
      s_media();
      s_mark();
      end_of_test();
   end
endmodule
